/* core/spi_master_slave_port.sv */
// Byte-wide full-duplex serial port, master or slave, with control and
// data registers on a plain strobe port. Pin inputs are synchronous.
`timescale 1ns/1ps
`include "spi_port_map.svh"

module spi_master_slave_port
  import spi_port_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic ss_n_i,
  input wire logic irq_enable_i,
  output logic irq_o,
  output logic spi_pins_owned_o
);

  ctrl_t ctrl_q;
  state_t st_q;
  logic [7:0] rx_q, sh_q, sh_d, fin_byte, rdata_q;
  logic [3:0] edge_q, div_q, half_m1;
  logic bit_q, sclk_q, sclk_prev_q, ss_prev_q;
  logic sclk_oe_n_q, mosi_oe_n_q, miso_oe_n_q, irq_q, pins_q;
  logic wr_data, wr_ctrl, rd_data, rd_ctrl;
  logic busy, accept, collide, tick;
  logic lead_ev, trail_ev, any_ev, launch, sample, last;
  logic fin_ev, ss_rise, din;

  assign wr_data = wr_i && (addr_i == `SPI_DATA_ADDR);
  assign wr_ctrl = wr_i && (addr_i == `SPI_CTRL_ADDR);
  assign rd_data = rd_i && (addr_i == `SPI_DATA_ADDR);
  assign rd_ctrl = rd_i && (addr_i == `SPI_CTRL_ADDR);

  // A byte written during a slave edge would corrupt the shift, so it
  // counts as a collision just like a write mid-byte.
  assign busy = (st_q != ST_IDLE) || any_ev;
  assign accept = wr_data && !busy;
  assign collide = wr_data && busy; // R14

  // Half period in core cycles is 1, 2, 4 or 8
  assign half_m1 = 4'((5'd1 << ctrl_q.rate) - 5'd1); // R8

  assign tick = ctrl_q.en && ctrl_q.master && (st_q == ST_RUN)
    && (div_q == 4'h0);
  assign ss_rise = ss_n_i && !ss_prev_q;
  assign din = ctrl_q.master ? miso_i : mosi_i; // R1 R2

  always_comb
  begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (ctrl_q.master)
    begin
      // Master ignores slave-select entirely
      lead_ev = tick && (sclk_q == ctrl_q.clock_idle_level); // R18
      trail_ev = tick && (sclk_q != ctrl_q.clock_idle_level);
    end
    else if (ctrl_q.en && !ss_n_i && (st_q != ST_WAIT)) // R10
    begin
      lead_ev = (sclk_i != sclk_prev_q) && (sclk_i != ctrl_q.clock_idle_level); // R23
      trail_ev = (sclk_i != sclk_prev_q) && (sclk_i == ctrl_q.clock_idle_level);
    end
  end

  assign any_ev = lead_ev || trail_ev;
  assign launch = ctrl_q.clock_launch_edge ? lead_ev : trail_ev; // R5 R7
  assign sample = ctrl_q.clock_launch_edge ? trail_ev : lead_ev; // R5 R7
  assign last = (edge_q == `SPI_LAST_EDGE); // R4

  // Shift left so the most significant bit leaves first
  always_comb
  begin
    sh_d = sh_q;
    if (sample && ctrl_q.clock_launch_edge && last)
    begin
      sh_d = {sh_q[6:0], din}; // R3
    end
    if (launch && !(ctrl_q.clock_launch_edge && edge_q == `SPI_FIRST_EDGE))
    begin
      sh_d = {sh_q[6:0], bit_q}; // R3 R20
    end
  end

  assign fin_ev = (any_ev && last && (ctrl_q.master || ctrl_q.clock_launch_edge))
    || ((st_q == ST_WAIT) && ss_rise); // R19 R21
  assign fin_byte = (st_q == ST_WAIT) ? sh_q : sh_d;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || !ctrl_q.en)
    begin
      st_q <= ST_IDLE;
      edge_q <= `SPI_FIRST_EDGE;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (accept && ctrl_q.master)
          begin
            st_q <= ST_RUN; // R17
            edge_q <= `SPI_FIRST_EDGE;
          end
          else if (any_ev && !ctrl_q.master)
          begin
            st_q <= ST_RUN;
            edge_q <= edge_q + 4'h1;
          end
        end
        ST_RUN:
        begin
          if (!ctrl_q.master && ss_n_i)
          begin
            st_q <= ST_IDLE; // R10
            edge_q <= `SPI_FIRST_EDGE;
          end
          else if (any_ev && last)
          begin
            edge_q <= `SPI_FIRST_EDGE;
            if (ctrl_q.master || ctrl_q.clock_launch_edge)
            begin
              st_q <= ST_IDLE; // R17 R21
            end
            else
            begin
              st_q <= ST_WAIT; // R21
            end
          end
          else if (any_ev)
          begin
            edge_q <= edge_q + 4'h1; // R4
          end
        end
        ST_WAIT:
        begin
          if (ss_rise || ctrl_q.master)
          begin
            st_q <= ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
          edge_q <= `SPI_FIRST_EDGE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sh_q <= `SPI_DATA_RST;
      bit_q <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        sh_q <= wdata_i; // R20 R22
      end
      else
      begin
        sh_q <= sh_d;
      end
      if (sample)
      begin
        bit_q <= din; // R5
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_q <= `SPI_DATA_RST;
    end
    else if (fin_ev)
    begin
      rx_q <= fin_byte; // R19 R21 R22
    end
  end

  // Divider and master clock; the clock rests at the idle level when idle
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      div_q <= 4'h0;
      sclk_q <= 1'b0;
    end
    else
    begin
      if (accept && ctrl_q.master)
      begin
        div_q <= half_m1;
      end
      else if (st_q == ST_RUN && ctrl_q.master)
      begin
        div_q <= (div_q == 4'h0) ? half_m1 : div_q - 4'h1; // R8
      end
      if (!ctrl_q.master || st_q != ST_RUN)
      begin
        sclk_q <= ctrl_q.clock_idle_level; // R6 R25
      end
      else if (tick)
      begin
        sclk_q <= ~sclk_q; // R4
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sclk_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_i;
      ss_prev_q <= ss_n_i;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= ctrl_t'(`SPI_CTRL_RST);
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q.en <= wdata_i[`SPI_EN_BIT]; // R15
        ctrl_q.master <= wdata_i[`SPI_MASTER_BIT]; // R16
        ctrl_q.clock_idle_level <= wdata_i[`SPI_CLOCK_IDLE_LEVEL_BIT]; // R6
        ctrl_q.clock_launch_edge <= wdata_i[`SPI_CLOCK_LAUNCH_EDGE_BIT]; // R7
        ctrl_q.rate <= wdata_i[`SPI_RATE_HI_BIT:`SPI_RATE_LO_BIT];
      end
      if (fin_ev)
      begin
        ctrl_q.done <= 1'b1; // R13
      end
      else if (wr_ctrl)
      begin
        ctrl_q.done <= wdata_i[`SPI_DONE_BIT]; // R13
      end
      else if (rd_data)
      begin
        ctrl_q.done <= 1'b0; // R13
      end
      if (collide)
      begin
        ctrl_q.write_collision_flag <= 1'b1; // R14
      end
      else if (wr_ctrl)
      begin
        ctrl_q.write_collision_flag <= wdata_i[`SPI_WRITE_COLLISION_FLAG_BIT]; // R14
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (rd_data)
    begin
      rdata_q <= rx_q; // R22
    end
    else if (rd_ctrl)
    begin
      rdata_q <= {ctrl_q[7:1],
        ctrl_q.master ? ctrl_q.rate[0] : ss_n_i}; // R9
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // Pin ownership follows the control register one cycle later
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sclk_oe_n_q <= 1'b1;
      mosi_oe_n_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
      pins_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      sclk_oe_n_q <= !(ctrl_q.en && ctrl_q.master); // R16
      mosi_oe_n_q <= !(ctrl_q.en && ctrl_q.master); // R1
      miso_oe_n_q <= !(ctrl_q.en && !ctrl_q.master); // R2
      pins_q <= ctrl_q.en; // R15
      irq_q <= ctrl_q.done && irq_enable_i; // R24
    end
  end

  assign rdata_o = rdata_q;
  assign sclk_o = sclk_q;
  assign sclk_oe_n_o = sclk_oe_n_q;
  assign mosi_o = sh_q[7]; // R25
  assign mosi_oe_n_o = mosi_oe_n_q;
  assign miso_o = sh_q[7]; // R25
  assign miso_oe_n_o = miso_oe_n_q;
  assign irq_o = irq_q;
  assign spi_pins_owned_o = pins_q;

  a_mosi_drive: assert property ( // R1
    @(posedge core_clk_i) disable iff (reset_i)
    (ctrl_q.en && ctrl_q.master) |=> !mosi_oe_n_o)
    else $error("data-out not driven in master mode");

  a_miso_drive: assert property ( // R2
    @(posedge core_clk_i) disable iff (reset_i)
    (ctrl_q.en && !ctrl_q.master) |=> (!miso_oe_n_o && mosi_oe_n_o))
    else $error("slave pin directions wrong");

  a_idle_clock_level: assert property ( // R6
    @(posedge core_clk_i) disable iff (reset_i)
    (ctrl_q.master && st_q == ST_IDLE && $stable(ctrl_q.clock_idle_level)
      && $past(st_q) == ST_IDLE) |-> (sclk_o == ctrl_q.clock_idle_level))
    else $error("master clock not at idle level");

  a_burst_length: assert property ( // R17
    @(posedge core_clk_i) disable iff (reset_i)
    (accept && ctrl_q.en && ctrl_q.master && ctrl_q.rate == 2'b00)
      |-> (!fin_ev [*8] ##1 !fin_ev [*8] ##1 fin_ev))
    else $error("fastest burst not sixteen cycles");

  a_collision_set: assert property ( // R14
    @(posedge core_clk_i) disable iff (reset_i)
    (wr_data && st_q != ST_IDLE) |=> ctrl_q.write_collision_flag)
    else $error("collision flag not set");

  a_collision_sticky: assert property ( // R14
    @(posedge core_clk_i) disable iff (reset_i)
    (ctrl_q.write_collision_flag && !wr_ctrl) |=> ctrl_q.write_collision_flag)
    else $error("collision flag dropped by itself");

  a_done_set: assert property ( // R13
    @(posedge core_clk_i) disable iff (reset_i)
    fin_ev |=> (ctrl_q.done && rx_q == $past(fin_byte)))
    else $error("end of byte not flagged or loaded");

  a_read_clears: assert property ( // R13
    @(posedge core_clk_i) disable iff (reset_i)
    (rd_data && !fin_ev) |=> (!ctrl_q.done && rdata_o == $past(rx_q)))
    else $error("data read did not clear done flag");

  a_select_read: assert property ( // R9
    @(posedge core_clk_i) disable iff (reset_i)
    (rd_ctrl && !ctrl_q.master) |=> (rdata_o[0] == $past(ss_n_i)))
    else $error("slave-select level not read back");

  a_select_gate: assert property ( // R10
    @(posedge core_clk_i) disable iff (reset_i)
    (!ctrl_q.master && ss_n_i) |-> !any_ev)
    else $error("slave shifted while deselected");

  a_irq_follow: assert property ( // R24
    @(posedge core_clk_i) disable iff (reset_i)
    (ctrl_q.done && irq_enable_i) |=> irq_o)
    else $error("interrupt request missing");

endmodule // spi_master_slave_port

/* core/spi_port_map.svh */
// Register offsets, field positions, reset values and counts of the
// serial port. Assumes an 8-bit register port on the core clock.
//
// Summary of operation
// R1 - Data-out line drives in master mode, is an input in slave mode.
// R2 - Data-in line is input in master mode, drives in slave mode.
// R3 - Each transfer moves one byte each way, most significant bit first.
// R4 - One bit each way per serial clock period; eight periods per byte.
// R5 - Data launches on one clock edge and is sampled on the other.
// R6 - Bit 3 set makes the serial clock idle high, clear idle low.
// R7 - Bit 2 set: leading edge launches data; clear: trailing edge launches.
// R8 - Master rate codes 00..11 give core clock divided by 2, 4, 8, 16.
// R9 - In slave mode, low rate bit reads back the slave-select pin level.
// R10 - Slave-select used in slave mode only; slave shifts only while low.
// R11 - Phase 0: far master frames each byte with slave-select low.
// R12 - Phase 1: far master may hold slave-select low across bytes.
// R13 - Done flag bit 7 sets per byte; cleared by write or data read.
// R14 - Collision flag bit 6 sets on data write mid-transfer; sticky.
// R15 - Enable bit 5 gives the pins to this port, else to two-wire port.
// R16 - Mode bit 4 set: master drives clock; clear: slave takes clock.
// R17 - Master: each data write makes exactly eight clock periods.
// R18 - Master ignores slave-select; far slaves selected by a port pin.
// R19 - Master shifts byte out, samples in, then flags and loads result.
// R20 - Slave: data write loads byte to send; each period shifts both ways.
// R21 - Slave loads received byte at end: eighth clock or select rising.
// R22 - Data writes give next byte to send; reads give last received.
// R23 - Far master and this port use identical polarity and phase.
// R24 - Interrupt request raised while done flag set and enable input high.
// R25 - Idle: master clock at idle level; output shows loaded byte MSB.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

`define SPI_DATA_ADDR 8'hF7
`define SPI_CTRL_ADDR 8'hF8
`define SPI_DATA_RST 8'h00
`define SPI_CTRL_RST 8'h04

`define SPI_DONE_BIT 7
`define SPI_WRITE_COLLISION_FLAG_BIT 6
`define SPI_EN_BIT 5
`define SPI_MASTER_BIT 4
`define SPI_CLOCK_IDLE_LEVEL_BIT 3
`define SPI_CLOCK_LAUNCH_EDGE_BIT 2
`define SPI_RATE_HI_BIT 1
`define SPI_RATE_LO_BIT 0

`define SPI_LAST_EDGE 4'hF
`define SPI_FIRST_EDGE 4'h0

`endif

/* core/spi_port_pkg.sv */
// Types shared by the serial port: control layout and sequencer states.
// Field order matches the bit positions in the map header.
package spi_port_pkg;

  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic en;
    logic master;
    logic clock_idle_level;
    logic clock_launch_edge;
    logic [1:0] rate;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_WAIT = 2'b11
  } state_t;

endpackage

/* dv/far_end.sv */
// Far-side model: a slave while the port masters, a master otherwise.
// Assumes the bench resolves the shared pins and sets polarity and phase.
`timescale 1ns/1ps
module far_end (
  input wire logic clk_i,
  input wire logic clock_idle_level_i,
  input wire logic clock_launch_edge_i,
  input wire logic watch_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o,
  output logic miso_o
);
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  int cnt = 0;
  initial
  begin
    sclk_o = 1'b0;
    mosi_o = 1'b1;
    ss_n_o = 1'b1;
    miso_o = 1'b1;
  end
  // Watch gate hides idle-level jumps while the port is reconfigured
  always @(sclk_i)
    if (watch_i)
    begin
      if ((sclk_i !== clock_idle_level_i) == !clock_launch_edge_i)
        rx_q = {rx_q[6:0], mosi_i};
      else if (sclk_i !== clock_idle_level_i)
        miso_o = tx_q[7 - cnt];
      if (sclk_i === clock_idle_level_i)
      begin
        cnt++;
        if (!clock_launch_edge_i)
          miso_o = (cnt < 8) ? tx_q[7 - cnt] : ~miso_o;
      end
    end
  task automatic xfer(input logic [7:0] d, input int half, input bit hold);
    @(posedge clk_i);
    sclk_o <= clock_idle_level_i;
    repeat (half) @(posedge clk_i);
    ss_n_o <= 1'b0;
    mosi_o <= clock_launch_edge_i ? ~d[7] : d[7];
    repeat (half) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      sclk_o <= ~clock_idle_level_i;
      if (clock_launch_edge_i)
        mosi_o <= d[7 - i];
      else
        rx_q <= {rx_q[6:0], miso_i};
      repeat (half) @(posedge clk_i);
      sclk_o <= clock_idle_level_i;
      if (clock_launch_edge_i)
        rx_q <= {rx_q[6:0], miso_i};
      else if (i < 7)
        mosi_o <= d[6 - i];
      repeat (half) @(posedge clk_i);
    end
    // Phase 1 lets the select stay low into the next byte
    if (!hold)
    begin
      ss_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
    end
  endtask
endmodule // far_end

/* dv/spi_master_slave_port_tb.sv */
// Bench for the serial port: register tasks, master and slave bytes.
// Assumes the far-side model; the shared pins are resolved here.
`timescale 1ns/1ps
`include "spi_port_map.svh"
module spi_master_slave_port_tb;
  localparam logic [7:0] CA = `SPI_CTRL_ADDR;
  localparam logic [7:0] DA = `SPI_DATA_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic clock_idle_level = 1'b0;
  logic clock_launch_edge = 1'b0;
  logic watch = 1'b0;
  logic irq_en = 1'b1;
  logic [7:0] rdata;
  logic sclk, sclk_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, irq, owned;
  logic f_sclk, f_mosi, f_ss_n, f_miso, sclk_w, mosi_w, miso_w;
  int n_mismatch = 0;
  int n_tests = 0;
  assign sclk_w = !sclk_oe_n ? sclk : f_sclk;
  assign mosi_w = !mosi_oe_n ? mosi : f_mosi;
  assign miso_w = !miso_oe_n ? miso : f_miso;
  always #20 clk = ~clk;
  spi_master_slave_port spi_master_slave_port_inst (.core_clk_i(clk),
    .reset_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .sclk_i(sclk_w), .sclk_o(sclk),
    .sclk_oe_n_o(sclk_oe_n), .mosi_i(mosi_w), .mosi_o(mosi),
    .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .ss_n_i(f_ss_n), .irq_enable_i(irq_en),
    .irq_o(irq), .spi_pins_owned_o(owned));
  far_end far_end_inst (.clk_i(clk), .clock_idle_level_i(clock_idle_level), .clock_launch_edge_i(clock_launch_edge),
    .watch_i(watch), .sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .sclk_o(f_sclk), .mosi_o(f_mosi), .ss_n_o(f_ss_n), .miso_o(f_miso));
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic pins(input logic [7:0] exp);
    chk("pins", exp, {4'h0, owned, sclk_oe_n, mosi_oe_n, miso_oe_n});
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
      @(posedge clk);
  endtask
  task automatic t_master(input logic [1:0] md, rt, input logic [7:0] mo, mi);
    logic p;
    int gap;
    int edges;
    gap = 0;
    edges = 0;
    watch = 1'b0;
    {clock_idle_level, clock_launch_edge} = md;
    wr(CA, {4'h3, md, rt});
    repeat (2) @(posedge clk);
    chk("idle clock", {7'h00, clock_idle_level}, {7'h00, sclk});
    pins(8'h09);
    far_end_inst.tx_q = mi;
    far_end_inst.cnt = 0;
    far_end_inst.miso_o <= clock_launch_edge ? ~mi[7] : mi[7];
    watch = 1'b1;
    wr(DA, mo);
    p = sclk;
    for (int i = 0; i < 400 && irq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      gap++;
      if (sclk !== p)
      begin
        edges++;
        if (edges > 1) chk("half period", 8'(1 << rt), 8'(gap));
        p = sclk;
        gap = 0;
      end
    end
    chk("clock edges", 8'h10, 8'(edges));
    chk("irq", 8'h01, {7'h00, irq});
    chk("idle again", {7'h00, clock_idle_level}, {7'h00, sclk});
    chk("far end got", mo, far_end_inst.rx_q);
    rchk("status", CA, {4'hB, md, rt});
    rchk("received", DA, mi);
    rchk("status read", CA, {4'h3, md, rt});
    chk("irq low", 8'h00, {7'h00, irq});
    $display("test master mode %0d done", md);
  endtask
  task automatic t_collide;
    watch = 1'b0;
    {clock_idle_level, clock_launch_edge} = 2'b00;
    wr(CA, 8'h33);
    wr(DA, 8'h6D);
    wr(DA, 8'hFF);
    wait_irq;
    rchk("collision", CA, 8'hF3);
    @(posedge clk);
    irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("irq masked", 8'h00, {7'h00, irq});
    @(posedge clk);
    irq_en <= 1'b1;
    wr(CA, 8'h73);
    rchk("sticky", CA, 8'h73);
    wr(CA, 8'h33);
    rchk("cleared", CA, 8'h33);
    $display("test collision done");
  endtask
  task automatic t_slave(input logic ph, input logic [7:0] so, si);
    watch = 1'b0;
    clock_idle_level = ph;
    clock_launch_edge = ph;
    wr(CA, {4'h2, ph, ph, 2'b00});
    wr(DA, so);
    repeat (2) @(posedge clk);
    pins(8'h0E);
    chk("first bit", {7'h00, so[7]}, {7'h00, miso});
    rchk("select level", CA, {4'h2, ph, ph, 2'b01});
    far_end_inst.xfer(si, 6, ph);
    wait_irq;
    chk("irq", 8'h01, {7'h00, irq});
    chk("far end got", so, far_end_inst.rx_q);
    rchk("status", CA, {4'hA, ph, ph, 1'b0, !ph});
    rchk("received", DA, si);
    if (ph)
    begin
      wr(DA, ~so);
      far_end_inst.xfer(~si, 6, 1'b0);
      wait_irq;
      chk("far end again", ~so, far_end_inst.rx_q);
      rchk("received again", DA, ~si);
    end
    $display("test slave phase %0d done", ph);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pins(8'h07);
    rchk("control", CA, 8'h05);
    rchk("data", DA, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
      t_master(2'(k), 2'(k), 8'hA5 ^ 8'(k), 8'h3C + 8'(k));
    t_collide;
    t_slave(1'b0, 8'h96, 8'h5A);
    t_slave(1'b1, 8'hC3, 8'h81);
    wr(CA, 8'h1C);
    repeat (2) @(posedge clk);
    pins(8'h07);
    rchk("disabled", CA, 8'h1C);
    $display("test disable done");
    conclude;
  end
  // Whole run is under 1,000 cycles; this bound is far beyond it
  initial
  begin
    #400000;
    n_mismatch++;
    conclude;
  end
endmodule // spi_master_slave_port_tb
